/* dv/pftm_fixture.sv */
`timescale 1ns/1ps
module pftm_fixture (
    input  wire logic       clk_in,
    input  wire logic [1:0] low_req_in,
    input  wire logic       pullup_en_in,
    output logic            upper_out,
    output logic            lower_out
);
    logic tog = 1'b0;
    always @(posedge clk_in) tog <= ~tog;
    // undriven strap rides the pull-up; without it the line wanders
    assign upper_out = low_req_in[1] ? 1'b0 : (pullup_en_in | tog);
    assign lower_out = low_req_in[0] ? 1'b0 : (pullup_en_in | tog);
endmodule : pftm_fixture

/* dv/pftm_monitor.sv */
`timescale 1ns/1ps
module pftm_monitor
    import pftm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic power_on_clear_in,
    input wire logic power_on_clear_level,
    input wire logic upper_memory_select_in,
    input wire logic lower_memory_select_in,
    input wire logic strap_pullup_en_out,
    input wire logic hold_ack_in,
    input wire logic muxed_addr_data_low_oe_out,
    input wire logic [pftm_pkg::PFTM_PIN_W-1:0] pin_oe_out,
    input wire logic crystal_output_oe_out,
    input wire logic pin_float_test_mode_out
);
    // ========================================
    // checks
    // ========================================
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    wire logic lo2 = !upper_memory_select_in && !lower_memory_select_in;
    wire logic md = pin_float_test_mode_out;
    sequence entry_s;
        $rose(power_on_clear_in) && lo2 ##1 lo2 [*4];
    endsequence
    sequence normal_s;
        $rose(power_on_clear_in) &&
            (upper_memory_select_in || lower_memory_select_in);
    endsequence
    strap_entry_a: assert property (entry_s |-> ##[0:3] md)
        else $error("test mode not entered");
    normal_start_a: assert property (normal_s |-> !md [*8])
        else $error("test mode entered with strap high");
    mode_holds_a: assert property (md && power_on_clear_in |=> md)
        else $error("test mode left early");
    pins_float_a: assert property (md |-> pin_oe_out == '0 &&
        !muxed_addr_data_low_oe_out) else $error("pin driven in test mode");
    crystal_drives_a: assert property (md |-> crystal_output_oe_out)
        else $error("crystal output floated");
    pullup_on_a: assert property (strap_pullup_en_out)
        else $error("strap pull-up off");
    hold_float_a: assert property
        (hold_ack_in |=> !muxed_addr_data_low_oe_out) else $error("hold drive");
    level_float_a: assert property
        (!power_on_clear_level [*4] |-> !muxed_addr_data_low_oe_out)
        else $error("low bus driven in level reset");
endmodule : pftm_monitor
bind pftm_top pftm_monitor u_pftm_monitor (.clk_sys_in, .nrst_in,
    .power_on_clear_in, .power_on_clear_level, .upper_memory_select_in,
    .lower_memory_select_in, .strap_pullup_en_out, .hold_ack_in,
    .muxed_addr_data_low_oe_out, .pin_oe_out, .crystal_output_oe_out,
    .pin_float_test_mode_out);

/* dv/pin_float_test_mode_entry_tb.sv */
`timescale 1ns/1ps
module pin_float_test_mode_entry_tb;
    logic clk = 1'b0, nrst = 1'b0, por = 1'b0, lvl = 1'b1, hold = 1'b0;
    logic [1:0] req = 2'b00;
    logic [7:0] ad_i = 8'h00;
    logic up, lo, pull, md, ad_oe, xoe, xpin;
    logic [7:0] ad_o, ad_in;
    logic [15:0] oe;
    logic [2:0] rows [4] = '{3'b111, 3'b100, 3'b010, 3'b000};
    int failures = 0, num_checks = 0;
    always #2 clk = ~clk;
    always @(posedge clk) ad_i <= ad_i + 8'h01;
    pftm_fixture u_pftm_fixture (.clk_in(clk), .low_req_in(req),
        .pullup_en_in(pull), .upper_out(up), .lower_out(lo));
    pftm_top u_pftm_top (.clk_sys_in(clk), .nrst_in(nrst),
        .power_on_clear_in(por), .power_on_clear_level(lvl),
        .upper_memory_select_in(up), .lower_memory_select_in(lo),
        .strap_pullup_en_out(pull), .hold_ack_in(hold),
        .core_ad_out_in(8'h5a), .core_ad_oe_in(1'b1),
        .muxed_addr_data_low_in(ad_i), .muxed_addr_data_low_out(ad_o),
        .muxed_addr_data_low_oe_out(ad_oe), .core_ad_in_out(ad_in),
        .core_pin_oe_in(16'hffff), .pin_oe_out(oe),
        .crystal_drive_in(1'b1), .crystal_output_pin_out(xpin),
        .crystal_output_oe_out(xoe), .pin_float_test_mode_out(md));
    // ========================================
    // helpers
    // ========================================
    task automatic check(input string nm, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // straps stay low well past the edge to cover the sync lag
    task automatic boot(input logic [1:0] r);
        @(posedge clk);
        por <= 1'b0;
        req <= r;
        repeat (10) @(posedge clk);
        por <= 1'b1;
        repeat (6) @(posedge clk);
        req <= 2'b00;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : boot
    // tests take about 150 clocks; allow 500
    initial begin
        #2000;
        failures++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("rst_mode", md, 1'b0);
        check("rst_pull", pull, 1'b1);
        @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            boot(rows[i][2:1]);
            check("mode", md, rows[i][0]);
            check("pin_oe", oe, rows[i][0] ? 16'h0000 : 16'hffff);
            check("ad_oe", ad_oe, !rows[i][0]);
            check("xtal_oe", xoe, 1'b1);
            check("xtal_pin", xpin, 1'b1);
            check("ad_out", ad_o, 8'h5a);
            check("ad_in", ad_in, 8'(ad_i - 8'h03));
        end
        @(posedge clk);
        hold <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("hold_oe", ad_oe, 1'b0);
        @(posedge clk);
        hold <= 1'b0;
        lvl <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("lvl_oe", ad_oe, 1'b0);
        @(posedge clk);
        lvl <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("bus_back", ad_oe, 1'b1);
        boot(2'b11);
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("stays", md, 1'b1);
        check("ad_float", ad_oe, 1'b0);
        check("oe_float", oe, 16'h0000);
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        check("exit", md, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        check("rerun_mode", md, 1'b0);
        check("rerun_oe", oe, 16'hffff);
        conclude();
    end
endmodule : pin_float_test_mode_entry_tb

/* hdl/pftm_pkg.sv */
package pftm_pkg;

    // =========================================================
    // widths
    // =========================================================
    localparam int unsigned PFTM_AD_W  = 8;
    localparam int unsigned PFTM_PIN_W = 16;

    // =========================================================
    // timing
    // =========================================================
    localparam int unsigned PFTM_CLK_NS       = 4;
    // least strap hold after the reset edge, in core clocks
    localparam int unsigned PFTM_HOLD_CLKS    = 1;
    localparam int unsigned PFTM_HOLD_CYC     = PFTM_HOLD_CLKS;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic PFTM_FLOAT_RST  = 1'b0;
    localparam logic PFTM_STRAP_RST  = 1'b1;

    typedef enum logic [1:0] {
        PFTM_IN_RESET,
        PFTM_SAMPLE,
        PFTM_NORMAL,
        PFTM_FLOAT
    } pftm_state_t;

endpackage : pftm_pkg

/* hdl/pftm_sync.sv */
`timescale 1ns/1ps
module pftm_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    // data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    // two-flop synchroniser; meta is read by q_out only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta  <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : pftm_sync

/* hdl/pftm_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - Both memory selects are sampled one clock after the synchronised reset rise; both low enters test mode.
// - Pin_float_test_mode in test mode all pins but the crystal output stay floated until the next reset.
// - In test mode only the crystal output keeps driving.
// - Both strap pins are weakly pulled high inside the device.
// - The low address/data byte floats during hold acknowledge and level reset.
module pftm_top
    import pftm_pkg::*;
(
    // clock and resets
    input  wire logic                         clk_sys_in,
    input  wire logic                         nrst_in,
    input  wire logic                         power_on_clear_in,
    input  wire logic                         power_on_clear_level,
    // strap pins, as seen on the pad
    input  wire logic                         upper_memory_select_in,
    input  wire logic                         lower_memory_select_in,
    output logic                              strap_pullup_en_out,
    // bus hold acknowledge from the core
    input  wire logic                         hold_ack_in,
    // low address/data byte from core and pad
    input  wire logic [pftm_pkg::PFTM_AD_W-1:0]  core_ad_out_in,
    input  wire logic                            core_ad_oe_in,
    input  wire logic [pftm_pkg::PFTM_AD_W-1:0]  muxed_addr_data_low_in,
    output logic      [pftm_pkg::PFTM_AD_W-1:0]  muxed_addr_data_low_out,
    output logic                                 muxed_addr_data_low_oe_out,
    output logic      [pftm_pkg::PFTM_AD_W-1:0]  core_ad_in_out,
    // all other pins' enables from the core
    input  wire logic [pftm_pkg::PFTM_PIN_W-1:0] core_pin_oe_in,
    output logic      [pftm_pkg::PFTM_PIN_W-1:0] pin_oe_out,
    // crystal output and mode status
    input  wire logic                         crystal_drive_in,
    output logic                              crystal_output_pin_out,
    output logic                              crystal_output_oe_out,
    output logic                              pin_float_test_mode_out
);
    import pftm_pkg::*;

    // =========================================================
    // reset release and pin synchronisers
    // =========================================================
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    logic                 clr_n_s;
    logic                 clr_lvl_n_s;
    logic                 upper_sel_s;
    logic                 lower_sel_s;
    logic [PFTM_AD_W-1:0] ad_s;

    pftm_sync #(.W(4), .RST_VAL(4'h0)) u_sync_ctl (
        .clk_in  (clk_sys_in),
        .nrst_in (rst_n),
        .d_in    ({power_on_clear_in, power_on_clear_level,
                   upper_memory_select_in, lower_memory_select_in}),
        .q_out   ({clr_n_s, clr_lvl_n_s, upper_sel_s, lower_sel_s})
    );

    // pad data is synchronous to the clock output, re-timed anyway
    pftm_sync #(.W(PFTM_AD_W), .RST_VAL(8'h00)) u_sync_ad (
        .clk_in  (clk_sys_in),
        .nrst_in (rst_n),
        .d_in    (muxed_addr_data_low_in),
        .q_out   (ad_s)
    );

    // =========================================================
    // decode helpers
    // =========================================================
    // both straps low selects test mode; low is the active level
    function automatic logic straps_low(input logic up, input logic lo);
        return !up && !lo;
    endfunction : straps_low

    function automatic logic is_float(input pftm_state_t s);
        return s == PFTM_FLOAT;
    endfunction : is_float

    // =========================================================
    // strap sampling state machine
    // =========================================================
    // both edge flops reset low, the asserted level of the reset pin,
    // so a pin already high after reset still counts as one edge
    pftm_state_t state;
    pftm_state_t next_state;
    logic        clr_n_d;
    logic        clr_rise;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            clr_n_d <= 1'b0;
        end else begin
            clr_n_d <= clr_n_s;
        end
    end
    assign clr_rise = clr_n_s && !clr_n_d;

    always_comb begin
        next_state = state;
        case (state)
            PFTM_IN_RESET: begin
                // sample one clock after the edge: fixture hold covers it
                if (clr_rise) begin
                    next_state = PFTM_SAMPLE;
                end
            end
            PFTM_SAMPLE: begin
                if (straps_low(upper_sel_s, lower_sel_s)) begin
                    next_state = PFTM_FLOAT;
                end else begin
                    next_state = PFTM_NORMAL;
                end
            end
            PFTM_NORMAL:   next_state = PFTM_NORMAL;
            PFTM_FLOAT:    next_state = PFTM_FLOAT;
            default:       next_state = PFTM_IN_RESET;
        endcase
        // a new reset pulse always restarts sampling
        if (!clr_n_s) begin
            next_state = PFTM_IN_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= PFTM_IN_RESET;
        end else begin
            state <= next_state;
        end
    end

    // =========================================================
    // pin drive
    // =========================================================
    logic float_all;
    logic ad_float;
    assign float_all = is_float(state);
    // level reset input low or hold acknowledged floats the low bus
    assign ad_float  = float_all || hold_ack_in || !clr_lvl_n_s;

    // =========================================================
    // mode status and strap pull-ups
    // =========================================================
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_float_test_mode_out <= PFTM_FLOAT_RST;
        end else begin
            pin_float_test_mode_out <= float_all;
        end
    end

    // weak pullups stay on so a loose strap reads high
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            strap_pullup_en_out <= PFTM_STRAP_RST;
        end else begin
            strap_pullup_en_out <= 1'b1;
        end
    end

    // =========================================================
    // general pin enables
    // =========================================================
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_out <= '0;
        end else if (float_all) begin
            pin_oe_out <= '0;
        end else begin
            pin_oe_out <= core_pin_oe_in;
        end
    end

    // =========================================================
    // low address/data byte
    // =========================================================
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            muxed_addr_data_low_oe_out <= 1'b0;
            muxed_addr_data_low_out    <= 8'h00;
        end else begin
            muxed_addr_data_low_oe_out <= core_ad_oe_in && !ad_float;
            muxed_addr_data_low_out    <= core_ad_out_in;
        end
    end

    // pad value to the core lags the pad by three clocks
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            core_ad_in_out <= 8'h00;
        end else begin
            core_ad_in_out <= ad_s;
        end
    end

    // =========================================================
    // crystal output
    // =========================================================
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            crystal_output_pin_out <= 1'b0;
            crystal_output_oe_out  <= 1'b0;
        end else begin
            // oscillator keeps running through test mode
            crystal_output_pin_out <= crystal_drive_in;
            crystal_output_oe_out  <= 1'b1;
        end
    end
endmodule : pftm_top
